// ---- shared/tmc_params.svh ----
`ifndef TMC_PARAMS_SVH
`define TMC_PARAMS_SVH

// ==========================================================
// timing
`define TMC_T_CLK_PS    4000
`define TMC_CYC_UP(t)   (((t) + `TMC_T_CLK_PS - 1) / `TMC_T_CLK_PS)
`define TMC_CYC_DN(t)   ((t) / `TMC_T_CLK_PS)
`define TMC_T_GATE_PS   7000
`define TMC_T_MRST_PS   40000
`define TMC_T_PRST_PS   75000
`define TMC_T_PROC_PS   900000
`define TMC_T_VALID_PS  1000000
`define TMC_T_RANGE_PS  40000000

// ==========================================================
// register byte addresses
`define TMC_A_CTRL      8'h00
`define TMC_A_EDGE      8'h04
`define TMC_A_DIS       8'h08
`define TMC_A_OFF       8'h0C
`define TMC_A_CMD       8'h10
`define TMC_A_STS       8'h14
`define TMC_A_ISTAT     8'h18
`define TMC_A_IMASK     8'h1C
`define TMC_A_RES1      8'h20
`define TMC_A_RES2      8'h24

// ==========================================================
// fields
`define TMC_B_FINE_HI   4
`define TMC_B_FINE_LO   0
`define TMC_B_FINE_EN   5
`define TMC_B_QUIET     6
`define TMC_B_PWR       7
`define TMC_B_STOPGATE  8
`define TMC_B_STARTGATE 9
`define TMC_FINE_MAX    5'h1F
`define TMC_C_TRIG      0
`define TMC_C_MRST      1
`define TMC_C_PRST      2
`define TMC_I_DONE      0
`define TMC_I_OVER      1
`define TMC_I_XSTART    2

// ==========================================================
// reset values and responses
`define TMC_RST_CTRL    10'h000
`define TMC_RST_EDGE    6'h07
`define TMC_RST_DIS     9'h000
`define TMC_RST_OFF     18'h00000
`define TMC_RST_MASK    3'h0
`define TMC_RESP_OKAY   2'h0
`define TMC_RESP_DECERR 2'h3

`endif

// ---- shared/tmc_pkg.sv ----
package tmc_pkg;

    typedef enum logic [1:0] {ST_SETTLE, ST_OPEN, ST_PROC, ST_DONE} tmc_meas_t;
    typedef logic [22:0] tmc_time_t;

endpackage : tmc_pkg

// ---- rtl/tmc_pin_sync.sv ----
module tmc_pin_sync #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    input  wire logic         ce,
    // pins
    input  wire logic [W-1:0] pin_in,
    // synchronised level and edges
    output logic      [W-1:0] level_o,
    output logic      [W-1:0] rise_o,
    output logic      [W-1:0] fall_o
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else if (ce) begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign level_o = s2_q;
    assign rise_o  = s2_q & ~s3_q;
    assign fall_o  = ~s2_q & s3_q;

endmodule : tmc_pin_sync

// ---- rtl/tmc_top.sv ----
`include "tmc_params.svh"

// Operation
// (R1) host enters mode: fine subdivision 31 and fine mode enable set
// (R2) one stop recorded per stop channel per measurement, later stops ignored
// (R3) host always pairs this mode with deferred processing
// (R4) host switches on differential input power separately
// (R5) each channel follows its rise/fall select bits; both zero disables it
// (R6) block pins gate stop rising and falling edges separately
// (R7) host disables an input by setting its three disable bits together
// (R8) by default inputs accept events right after reset, stops before start too
// (R9) stop gating keeps stops closed until start, then at least 7 ns
// (R10) start gating closes start channel after first start
// (R11) only the first start is used; extra starts are flagged
// (R12) start offset added to every stop result; host subtracts it
// (R13) trigger 400 ns after last stop; data valid within 1 us
// (R14) intervals from zero to 40 us are measured; the 23-bit RANGE_LIM holds the default of 10000 cycles, 40 us, without wrapping
// (R15) host keeps rate under 500 kHz per channel, 1 MHz per device
// (R16) two stop channels against one shared start
// (R17) deferred processing starts on trigger pin rise or software trigger
// (R18) host reads results only when not empty, at index 8 and 9
// (R19) inputs open 40 ns after power/master reset, 75 ns after partial reset
module tmc_top #(
    parameter int RANGE_CYC = `TMC_CYC_DN(`TMC_T_RANGE_PS)
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        ce,
    // measurement pins
    input  wire logic        start_pin,
    input  wire logic [1:0]  stop_pin,
    input  wire logic [1:0]  stop_block_rise_pin,
    input  wire logic [1:0]  stop_block_fall_pin,
    input  wire logic        alu_trigger_pin,
    // axi4-lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // status
    output logic [1:0]       fifo_empty_flag,
    output logic             irq
);

    localparam tmc_pkg::tmc_time_t GATE_CYC  =
        tmc_pkg::tmc_time_t'(`TMC_CYC_UP(`TMC_T_GATE_PS));
    localparam tmc_pkg::tmc_time_t RANGE_LIM = tmc_pkg::tmc_time_t'(RANGE_CYC);
    localparam logic [4:0] MRST_CYC = 5'(`TMC_CYC_UP(`TMC_T_MRST_PS));
    localparam logic [4:0] PRST_CYC = 5'(`TMC_CYC_UP(`TMC_T_PRST_PS));
    localparam logic [7:0] PROC_CYC = 8'(`TMC_CYC_UP(`TMC_T_PROC_PS));
    localparam int         VALID_N  = `TMC_CYC_DN(`TMC_T_VALID_PS);

    // ==========================================================
    // state
    logic aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d, irq_q, irq_d;
    logic [7:0]  awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d, wv;
    logic [3:0]  wstrb_q, wstrb_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic [9:0]  ctrl_q, ctrl_d;
    logic [5:0]  edge_q, edge_d;
    logic [8:0]  dis_q, dis_d;
    logic [17:0] off_q, off_d;
    logic [2:0]  mask_q, mask_d, stat_q, stat_d, stat_clr, ev;
    logic        sw_trig, sw_mrst, sw_prst;
    logic [1:0]  pop;

    tmc_pkg::tmc_meas_t state_q, state_d;
    tmc_pkg::tmc_time_t time_q, time_d, start_t_q, start_t_d, elapsed;
    tmc_pkg::tmc_time_t stop_t_q [2];
    tmc_pkg::tmc_time_t stop_t_d [2];
    tmc_pkg::tmc_time_t res_q [2];
    tmc_pkg::tmc_time_t res_d [2];
    logic [4:0]  cnt_q, cnt_d;
    logic [7:0]  proc_q, proc_d;
    logic [1:0]  hit_q, hit_d, empty_q, empty_d, stop_acc;
    logic        start_seen_q, start_seen_d, over_q, over_d;
    logic [2:0]  chan_ev, blk_r, blk_f;
    logic [7:0]  lvl_w, rise_w, fall_w;
    logic        mode_act, inputs_ok, stop_open;

    // ==========================================================
    // pin synchronisers
    tmc_pin_sync #(.W(8)) u_sync (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .ce      (ce),
        .pin_in  ({alu_trigger_pin, stop_block_fall_pin, stop_block_rise_pin,
                   stop_pin, start_pin}),
        .level_o (lvl_w),
        .rise_o  (rise_w),
        .fall_o  (fall_w)
    );

    // ==========================================================
    // input qualification
    assign mode_act  = (ctrl_q[`TMC_B_FINE_HI:`TMC_B_FINE_LO] == `TMC_FINE_MAX)
                       && ctrl_q[`TMC_B_FINE_EN];
    assign inputs_ok = (state_q == tmc_pkg::ST_OPEN) && mode_act && ctrl_q[`TMC_B_PWR];
    assign blk_r     = {lvl_w[4:3], 1'b0};
    assign blk_f     = {lvl_w[6:5], 1'b0};
    assign elapsed   = time_q - start_t_q;
    // (R8) (R9) default open, stop gate
    assign stop_open = inputs_ok && !over_q && (!ctrl_q[`TMC_B_STOPGATE]
                       || (start_seen_q && elapsed >= GATE_CYC));

    for (genvar k = 0; k < 3; k++) begin : g_chan
        // (R5) (R6) (R7) edge selection and blocking
        assign chan_ev[k] = ((edge_q[k] & rise_w[k] & ~blk_r[k])
                            | (edge_q[k+3] & fall_w[k] & ~blk_f[k]))
                            & ~(&dis_q[3*k+2:3*k]);
    end
    for (genvar k = 0; k < 2; k++) begin : g_stop
        // (R2) (R16) first stop only
        assign stop_acc[k] = stop_open && chan_ev[k+1] && !hit_q[k];
    end

    // ==========================================================
    // register access helpers
    function automatic logic is_mapped(input logic [7:0] a);
        return a inside {`TMC_A_CTRL, `TMC_A_EDGE, `TMC_A_DIS, `TMC_A_OFF, `TMC_A_CMD,
                         `TMC_A_STS, `TMC_A_ISTAT, `TMC_A_IMASK, `TMC_A_RES1, `TMC_A_RES2};
    endfunction : is_mapped

    function automatic logic [31:0] reg_rd(input logic [7:0] a);
        case (a)
            `TMC_A_CTRL:  return {22'h000000, ctrl_q};
            `TMC_A_EDGE:  return {26'h0000000, edge_q};
            `TMC_A_DIS:   return {23'h000000, dis_q};
            `TMC_A_OFF:   return {14'h0000, off_q};
            `TMC_A_STS:   return {26'h0000000, state_q == tmc_pkg::ST_PROC, mode_act,
                                  start_seen_q, inputs_ok, empty_q};
            `TMC_A_ISTAT: return {29'h00000000, stat_q};
            `TMC_A_IMASK: return {29'h00000000, mask_q};
            `TMC_A_RES1:  return {9'h000, res_q[0]};
            `TMC_A_RES2:  return {9'h000, res_q[1]};
            default:      return 32'h00000000;
        endcase
    endfunction : reg_rd

    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                           input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction : wmerge

    // ==========================================================
    // bus slave and configuration
    always_comb begin
        aw_got_d = aw_got_q;
        awaddr_d = awaddr_q;
        w_got_d  = w_got_q;
        wdata_d  = wdata_q;
        wstrb_d  = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d  = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        ctrl_d   = ctrl_q;
        edge_d   = edge_q;
        dis_d    = dis_q;
        off_d    = off_q;
        mask_d   = mask_q;
        stat_clr = '0;
        sw_trig  = 1'b0;
        sw_mrst  = 1'b0;
        sw_prst  = 1'b0;
        pop      = '0;
        wv       = '0;
        if (s_axi_awvalid && awready_q) begin
            aw_got_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_got_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (aw_got_q && w_got_q && !bvalid_q) begin
            aw_got_d = 1'b0;
            w_got_d  = 1'b0;
            bvalid_d = 1'b1;
            bresp_d  = is_mapped(awaddr_q) ? `TMC_RESP_OKAY : `TMC_RESP_DECERR;
            wv       = wmerge(reg_rd(awaddr_q), wdata_q, wstrb_q);
            case (awaddr_q)
                `TMC_A_CTRL:  ctrl_d = wv[9:0];
                `TMC_A_EDGE:  edge_d = wv[5:0];
                `TMC_A_DIS:   dis_d  = wv[8:0];
                `TMC_A_OFF:   off_d  = wv[17:0];
                `TMC_A_IMASK: mask_d = wv[2:0];
                `TMC_A_ISTAT: stat_clr = wdata_q[2:0] & {3{wstrb_q[0]}};
                `TMC_A_CMD: begin
                    sw_trig = wstrb_q[0] & wdata_q[`TMC_C_TRIG];
                    sw_mrst = wstrb_q[0] & wdata_q[`TMC_C_MRST];
                    sw_prst = wstrb_q[0] & wdata_q[`TMC_C_PRST];
                end
                default: ;
            endcase
        end
        // sticky events win over a clear in the same cycle
        stat_d = (stat_q & ~stat_clr) | ev;
        irq_d  = |(stat_d & mask_d);
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rdata_d  = reg_rd(s_axi_araddr);
            rresp_d  = is_mapped(s_axi_araddr) ? `TMC_RESP_OKAY : `TMC_RESP_DECERR;
            pop[0]   = (s_axi_araddr == `TMC_A_RES1) && !empty_q[0];
            pop[1]   = (s_axi_araddr == `TMC_A_RES2) && !empty_q[1];
        end
        awready_d = !aw_got_d && !bvalid_d;
        wready_d  = !w_got_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    // ==========================================================
    // measurement sequence
    always_comb begin
        state_d      = state_q;
        cnt_d        = cnt_q;
        proc_d       = proc_q;
        time_d       = time_q;
        start_t_d    = start_t_q;
        stop_t_d     = stop_t_q;
        res_d        = res_q;
        hit_d        = hit_q;
        empty_d      = empty_q | pop;
        start_seen_d = start_seen_q;
        over_d       = over_q;
        ev           = '0;
        unique case (state_q)
            tmc_pkg::ST_SETTLE: begin
                // (R19) settle count after reset
                if (cnt_q == 5'h01) begin
                    state_d = tmc_pkg::ST_OPEN;
                end else begin
                    cnt_d = cnt_q - 5'h01;
                end
            end
            tmc_pkg::ST_OPEN: begin
                time_d = time_q + 23'h000001;
                // (R10) (R11) first start only
                if (inputs_ok && chan_ev[0] && !start_seen_q) begin
                    start_seen_d = 1'b1;
                    start_t_d    = time_q;
                end else if (inputs_ok && chan_ev[0] && !ctrl_q[`TMC_B_STARTGATE]) begin
                    ev[`TMC_I_XSTART] = 1'b1;
                end
                for (int k = 0; k < 2; k++) begin
                    if (stop_acc[k]) begin
                        hit_d[k]    = 1'b1;
                        stop_t_d[k] = time_q;
                    end
                end
                // (R14) range limit closes stops
                if (start_seen_q && !over_q && elapsed >= RANGE_LIM) begin
                    over_d           = 1'b1;
                    ev[`TMC_I_OVER]  = 1'b1;
                end
                // (R17) deferred or automatic start of processing
                if (ctrl_q[`TMC_B_QUIET] ? (sw_trig || rise_w[7])
                                         : (start_seen_q && |hit_q)) begin
                    state_d = tmc_pkg::ST_PROC;
                    proc_d  = PROC_CYC;
                end
            end
            tmc_pkg::ST_PROC: begin
                // (R13) bounded processing time
                if (proc_q == 8'h01) begin
                    state_d         = tmc_pkg::ST_DONE;
                    ev[`TMC_I_DONE] = 1'b1;
                    for (int k = 0; k < 2; k++) begin
                        if (hit_q[k]) begin
                            // (R12) start offset added
                            res_d[k]   = stop_t_q[k] - start_t_q + {5'h00, off_q};
                            empty_d[k] = 1'b0;
                        end
                    end
                end else begin
                    proc_d = proc_q - 8'h01;
                end
            end
            tmc_pkg::ST_DONE: ;
        endcase
        if (sw_mrst || sw_prst) begin
            state_d      = tmc_pkg::ST_SETTLE;
            cnt_d        = sw_mrst ? MRST_CYC : PRST_CYC;
            time_d       = '0;
            start_t_d    = '0;
            hit_d        = '0;
            start_seen_d = 1'b0;
            over_d       = 1'b0;
            if (sw_mrst) begin
                empty_d = 2'b11;
            end
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            aw_got_q <= 1'b0;   w_got_q <= 1'b0;   awaddr_q <= '0;
            wdata_q <= '0;      wstrb_q <= '0;     bvalid_q <= 1'b0;
            bresp_q <= `TMC_RESP_OKAY;             rvalid_q <= 1'b0;
            rdata_q <= '0;      rresp_q <= `TMC_RESP_OKAY;
            awready_q <= 1'b1;  wready_q <= 1'b1;  arready_q <= 1'b1;
            ctrl_q <= `TMC_RST_CTRL;  edge_q <= `TMC_RST_EDGE;  dis_q <= `TMC_RST_DIS;
            off_q <= `TMC_RST_OFF;    mask_q <= `TMC_RST_MASK;  stat_q <= '0;
            irq_q <= 1'b0;      state_q <= tmc_pkg::ST_SETTLE;  cnt_q <= MRST_CYC;
            proc_q <= '0;       time_q <= '0;      start_t_q <= '0;
            stop_t_q <= '{default: '0};            res_q <= '{default: '0};
            hit_q <= '0;        empty_q <= 2'b11;
            start_seen_q <= 1'b0;                  over_q <= 1'b0;
        end else if (ce) begin
            aw_got_q <= aw_got_d;  w_got_q <= w_got_d;  awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;    wstrb_q <= wstrb_d;  bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;    rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;    rresp_q <= rresp_d;
            awready_q <= awready_d;  wready_q <= wready_d;  arready_q <= arready_d;
            ctrl_q <= ctrl_d;   edge_q <= edge_d;   dis_q <= dis_d;
            off_q <= off_d;     mask_q <= mask_d;   stat_q <= stat_d;
            irq_q <= irq_d;     state_q <= state_d; cnt_q <= cnt_d;
            proc_q <= proc_d;   time_q <= time_d;   start_t_q <= start_t_d;
            stop_t_q <= stop_t_d;                   res_q <= res_d;
            hit_q <= hit_d;     empty_q <= empty_d;
            start_seen_q <= start_seen_d;           over_q <= over_d;
        end
    end

    assign s_axi_awready   = awready_q;
    assign s_axi_wready    = wready_q;
    assign s_axi_bvalid    = bvalid_q;
    assign s_axi_bresp     = bresp_q;
    assign s_axi_arready   = arready_q;
    assign s_axi_rvalid    = rvalid_q;
    assign s_axi_rdata     = rdata_q;
    assign s_axi_rresp     = rresp_q;
    assign fifo_empty_flag = empty_q;
    assign irq             = irq_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    chk_single_hit: assert property ( // (R2)
        (ce && hit_q[0] && !sw_mrst && !sw_prst) |=> hit_q[0] && $stable(stop_t_q[0]))
        else $error("second stop overwrote first");
    chk_chan_off: assert property ( // (R5)
        (ce && !edge_q[2] && !edge_q[5] && !hit_q[1]) |=> !hit_q[1])
        else $error("disabled channel recorded a stop");
    chk_block_pin: assert property ( // (R6)
        (ce && lvl_w[3] && !edge_q[4] && !hit_q[0]) |=> !hit_q[0])
        else $error("blocked rising edge recorded");
    chk_open_default: assert property ( // (R8)
        (ce && stop_open && !ctrl_q[`TMC_B_STOPGATE] && chan_ev[1] && !hit_q[0]
         && !sw_mrst && !sw_prst) |=> hit_q[0])
        else $error("open stop input missed an edge");
    chk_stop_gate: assert property ( // (R9)
        ($rose(hit_q[0]) && ctrl_q[`TMC_B_STOPGATE])
        |-> start_seen_q && (stop_t_q[0] - start_t_q >= GATE_CYC))
        else $error("gated stop accepted too early");
    chk_start_once: assert property ( // (R11)
        (ce && start_seen_q && !sw_mrst && !sw_prst) |=> $stable(start_t_q))
        else $error("later start replaced first");
    chk_offset_add: assert property ( // (R12)
        (ce && state_q == tmc_pkg::ST_PROC && proc_q == 8'h01 && hit_q[0]
         && !sw_mrst && !sw_prst)
        |=> res_q[0] == $past(stop_t_q[0] - start_t_q + {5'h00, off_q}))
        else $error("result lacks start offset");
    chk_valid_time: assert property ( // (R13)
        (ce && state_q == tmc_pkg::ST_OPEN && state_d == tmc_pkg::ST_PROC)
        |-> ##[1:VALID_N] (state_q != tmc_pkg::ST_PROC))
        else $error("data not valid in time");
    chk_range_stop: assert property ( // (R14)
        (ce && over_q && !hit_q[1] && !sw_mrst && !sw_prst) |=> !hit_q[1])
        else $error("stop accepted past range");
    chk_quiet_trig: assert property ( // (R17)
        (ce && state_q == tmc_pkg::ST_OPEN && ctrl_q[`TMC_B_QUIET] && !sw_trig
         && !rise_w[7]) |=> state_q != tmc_pkg::ST_PROC)
        else $error("processing began without trigger");
    chk_settle_time: assert property ( // (R19)
        (ce && sw_prst && !sw_mrst) |=> state_q == tmc_pkg::ST_SETTLE && cnt_q == PRST_CYC)
        else $error("partial reset settle count wrong");

    cov_both_done: cover property (state_q == tmc_pkg::ST_DONE && empty_q == 2'b00);
    cov_extra_start: cover property (ev[`TMC_I_XSTART]);
    cov_overrange: cover property (ev[`TMC_I_OVER]);

endmodule : tmc_top

// ---- verification/tmc_pulse_src.sv ----
module tmc_pulse_src (
    // clock and command
    input  wire logic       clk_sys,
    input  wire logic       go,
    input  wire logic       early,
    input  wire logic [7:0] dly1,
    input  wire logic [7:0] dly2,
    // pins
    output logic            start_pin,
    output logic [1:0]      stop_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 99;
    function automatic logic hit(input int t, input logic [7:0] d);
        return d != 8'h00 && (t == 10 + int'(d) || t == 11 + int'(d));
    endfunction : hit
    // one burst per run; its paired stops 8 cycles apart exceed the rate limit
    always @(posedge clk_sys) cnt <= go ? 0 : (cnt < 99 ? cnt + 1 : cnt);
    // early runs add a second start
    assign start_pin = cnt == 10 || cnt == 11 || (early && cnt inside {14, 15});
    // a second stop follows on channel 1
    assign stop_pin[0] = hit(cnt, dly1) || hit(cnt - 8, dly1) || (early && cnt inside {2, 3});
    assign stop_pin[1] = hit(cnt, dly2);
endmodule : tmc_pulse_src

// ---- verification/testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, nrst = 0, go = 0, early = 0, trig = 0, arvalid = 0, rready = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, awready, wready, bvalid, arready, rvalid, irq;
    logic [7:0] d1 = 0, d2 = 0, awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [1:0] blk_r = 0, blk_f = 0, wresp, bresp, rresp, empty, stop_pin;
    logic start_pin;
    int miscompares = 0, checked = 0, cyc = 0;
    tmc_pulse_src u_src (.clk_sys(clk_sys), .go(go), .early(early), .dly1(d1), .dly2(d2),
        .start_pin(start_pin), .stop_pin(stop_pin));
    tmc_top #(.RANGE_CYC(64)) u_dut (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1),
        .start_pin(start_pin), .stop_pin(stop_pin), .stop_block_rise_pin(blk_r),
        .stop_block_fall_pin(blk_f), .alu_trigger_pin(trig), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .fifo_empty_flag(empty), .irq(irq));
    // ==========================================================
    // bus and compare tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb = 1'b0;
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!tb) begin
            @(negedge clk_sys);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            wresp = bresp;
            @(posedge clk_sys);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) bready <= 1'b0;
        end
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr = 1'b0;
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!tr) begin
            @(negedge clk_sys);
            ta = arvalid && arready;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk_sys);
            if (ta) arvalid <= 1'b0;
            if (tr) rready <= 1'b0;
        end
    endtask : rd
    task automatic run(input logic [7:0] a, input logic [7:0] b, input logic e, input logic p);
        logic [31:0] d;
        logic [1:0] r;
        wr(8'h10, 32'h2);
        for (int n = 0; n < 20 && d[2] !== 1'b1; n++) rd(8'h14, d, r);
        chk(d & 32'h4, 32'h4);
        d1 <= a;
        d2 <= b;
        early <= e;
        go <= 1'b1;
        @(posedge clk_sys) go <= 1'b0;
        // trigger well after the last stop
        repeat (170) @(posedge clk_sys);
        if (p) begin
            trig <= 1'b1;
            repeat (4) @(posedge clk_sys);
            trig <= 1'b0;
        end else wr(8'h10, 32'h1);
        repeat (246) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : run
    // ==========================================================
    // scenarios
    task automatic t_reset;
        logic [31:0] d;
        logic [1:0] r;
        @(negedge clk_sys);
        chk({30'h0, empty}, 32'h3);
        chk({31'h0, irq}, 32'h0);
        rd(8'h04, d, r);
        chk(d, 32'h7);
        rd(8'h40, d, r);
        chk({30'h0, r}, 32'h3);
        chk(d, 32'h0);
        wr(8'h40, 32'h1);
        chk({30'h0, wresp}, 32'h3);
        $display("test reset done");
    endtask : t_reset
    task automatic t_meas;
        logic [31:0] d;
        logic [1:0] r;
        wr(8'h00, 32'hFF);
        wr(8'h0C, 32'h3FFFF);
        wr(8'h1C, 32'h1);
        run(8'd20, 8'd33, 1'b0, 1'b0);
        chk({30'h0, empty}, 32'h0);
        chk({31'h0, irq}, 32'h1);
        rd(8'h20, d, r);
        chk(d, 32'h3FFFF + 32'd20);
        rd(8'h24, d, r);
        @(negedge clk_sys);
        chk(d, 32'h3FFFF + 32'd33);
        chk({30'h0, empty}, 32'h3);
        wr(8'h18, 32'h1);
        @(negedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        $display("test measure done");
    endtask : t_meas
    task automatic t_gate;
        logic [31:0] d;
        logic [1:0] r;
        wr(8'h00, 32'h1FF);
        wr(8'h0C, 32'h0);
        run(8'd0, 8'd2, 1'b1, 1'b1);
        chk({30'h0, empty}, 32'h1);
        rd(8'h18, d, r);
        chk(d, 32'h7);
        wr(8'h10, 32'h4);
        rd(8'h14, d, r);
        chk(d & 32'h7, 32'h1);
        rd(8'h24, d, r);
        chk(d, 32'h2);
        $display("test gate done");
    endtask : t_gate
    task automatic t_block;
        logic [31:0] d;
        logic [1:0] r;
        wr(8'h00, 32'h2FF);
        wr(8'h04, 32'h27);
        wr(8'h08, 32'h38);
        wr(8'h18, 32'h4);
        blk_r <= 2'b10;
        blk_f <= 2'b10;
        run(8'd20, 8'd20, 1'b1, 1'b0);
        chk({30'h0, empty}, 32'h3);
        rd(8'h18, d, r);
        chk(d & 32'h4, 32'h0);
        $display("test block done");
    endtask : t_block
    task automatic conclude;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 6000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        t_reset();
        t_meas();
        t_gate();
        t_block();
        conclude();
    end
endmodule : testbench
